// file: src/alasp_top.sv
// List addressing registers and sample phase control of the converter
// How it works
// - Base pointer writable only disabled or special
// - Base pointer gives result list RAM base
// - List zero offset always reads zero
// - Offsets count samples, not bytes
// - List one offset writable disabled or special
// - List one offset serves result addresses
// - Mux connects exactly one selected channel
// - Two-cycle pump phase before sampling
// - First two sample cycles go through buffer
// - Rest of sample time connects directly
// - Hold disconnects input from storage node
// - Result address is base plus offset plus index
// - Sample time code 0..20 gives 4..24
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "alasp_map.svh"

module alasp_top (
  // Clock and reset
  input  wire logic                       SYS_CLK_I,
  input  wire logic                       RESET_I,
  // Register port
  input  wire logic [7:0]                 REG_ADDR_I,
  input  wire logic [7:0]                 REG_WDATA_I,
  input  wire logic                       REG_WR_I,
  input  wire logic                       REG_RD_I,
  output logic      [7:0]                 REG_RDATA_O,
  // Conversion control
  input  wire logic                       CONV_START_I,
  input  wire logic [`ALASP_SMP_W-1:0]    SMP_SEL_I,
  input  wire logic [`ALASP_CHAN_W-1:0]   CHAN_SEL_I,
  input  wire logic [`ALASP_IDX_W-1:0]    RESULT_INDEX_I,
  input  wire logic [9:0]                 RESULT_DATA_I,
  // Analog switch controls
  output logic [(1<<`ALASP_CHAN_W)-1:0]   CHAN_CONNECT_O,
  output logic                            PUMP_O,
  output logic                            BUF_SAMPLE_O,
  output logic                            DIRECT_SAMPLE_O,
  output logic                            HOLD_O,
  output logic                            BUSY_O,
  // Result store to system RAM
  output logic                            RAM_WR_O,
  output logic [`ALASP_ADDR_W-1:0]        RAM_ADDR_O,
  output logic [15:0]                     RAM_WDATA_O
);

  // ****************************************************************
  // Converter clock divider: 10 MHz system clock halved
  // ****************************************************************
  logic div_r;
  logic cc_en;

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      div_r <= 1'b0;
    end else begin
      div_r <= ~div_r;
    end
  end
  assign cc_en = div_r;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  alasp_seq_if sif ();

  alasp_seq u_seq (
    .clk_i   (SYS_CLK_I),
    .reset_i (RESET_I),
    .cc_en_i (cc_en),
    .sif     (sif)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [`ALASP_PTR_W-1:0]          base_ptr;
    logic [`ALASP_OFF_W-1:0]          l1_off;
    logic                             enable;
    logic                             sacc;
    logic                             list_sel;
    logic [7:0]                       rdata;
    logic                             start;
    logic [`ALASP_SMP_W-1:0]          sample_time_select;
    logic [`ALASP_CHAN_W-1:0]         chan;
    logic [(1<<`ALASP_CHAN_W)-1:0]    connect;
    logic                             pump;
    logic                             bufs;
    logic                             direct;
    logic                             hold;
    logic                             busy;
    logic                             ram_wr;
    logic [`ALASP_ADDR_W-1:0]         ram_addr;
    logic [15:0]                      ram_data;
  } alasp_top_state_type;

  alasp_top_state_type st_r;
  alasp_top_state_type st_nxt;

  logic                        wr_ok;
  logic [`ALASP_OFF_W-1:0]     act_off;
  logic [`ALASP_ADDR_W-1:0]    res_addr;
  logic [`ALASP_ADDR_W-1:0]    base_bytes;
  logic [`ALASP_ADDR_W-1:0]    sample_bytes;

  // Address registers are locked while enabled and special access is clear
  assign wr_ok = ~st_r.enable | st_r.sacc;

  // Active list offset; list zero is a fixed null offset
  assign act_off = st_r.list_sel ? st_r.l1_off
                                 : `ALASP_LIST0_OFFSET;

  // Samples are 16-bit, so the sample count is doubled into bytes
  assign base_bytes   = {st_r.base_ptr, 2'b00};
  assign sample_bytes = {{(`ALASP_ADDR_W-`ALASP_OFF_W-2){1'b0}},
                         ({1'b0, act_off} +
                          {2'b00, RESULT_INDEX_I}), 1'b0};
  assign res_addr     = base_bytes + sample_bytes;

  assign sif.start   = st_r.start;
  assign sif.smp_sel = st_r.sample_time_select;

  // Next state: register port, sequencer launch and result store
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rdata  = 8'h00;
    st_nxt.start  = 1'b0;
    st_nxt.ram_wr = 1'b0;
    // Register writes
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        `ALASP_OFF_RBP_HIGH: begin
          if (wr_ok) begin
            st_nxt.base_ptr[17:14] = REG_WDATA_I[3:0];
          end
        end
        `ALASP_OFF_RBP_MID: begin
          if (wr_ok) begin
            st_nxt.base_ptr[13:6] = REG_WDATA_I;
          end
        end
        `ALASP_OFF_RBP_LOW: begin
          if (wr_ok) begin
            st_nxt.base_ptr[5:0] = REG_WDATA_I[7:2];
          end
        end
        `ALASP_OFF_L1_OFFSET: begin
          if (wr_ok) begin
            st_nxt.l1_off = REG_WDATA_I[6:0];
          end
        end
        `ALASP_OFF_CONTROL: begin
          st_nxt.enable   = REG_WDATA_I[`ALASP_CTL_EN_BIT];
          st_nxt.sacc     = REG_WDATA_I[`ALASP_CTL_SACC_BIT];
          st_nxt.list_sel = REG_WDATA_I[`ALASP_CTL_LSEL_BIT];
        end
        default: begin
        end
      endcase
    end
    // Register reads, answered in the following cycle
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        `ALASP_OFF_RBP_HIGH:  st_nxt.rdata = {4'h0, st_r.base_ptr[17:14]};
        `ALASP_OFF_RBP_MID:   st_nxt.rdata = st_r.base_ptr[13:6];
        `ALASP_OFF_RBP_LOW:   st_nxt.rdata = {st_r.base_ptr[5:0], 2'b00};
        `ALASP_OFF_L0_OFFSET: st_nxt.rdata = {1'b0, `ALASP_LIST0_OFFSET};
        `ALASP_OFF_L1_OFFSET: st_nxt.rdata = {1'b0, st_r.l1_off};
        `ALASP_OFF_CONTROL:   st_nxt.rdata = {5'h00, st_r.list_sel,
                                              st_r.sacc, st_r.enable};
        `ALASP_OFF_STATUS:    st_nxt.rdata = {3'h0, sif.hold_on,
                                              sif.direct_on, sif.buf_on,
                                              sif.pump_on, sif.busy};
        default:              st_nxt.rdata = 8'h00;
      endcase
    end
    // Launch a conversion only when enabled and idle
    if (CONV_START_I && st_r.enable && !sif.busy && !st_r.start) begin
      st_nxt.start = 1'b1;
      st_nxt.sample_time_select   = SMP_SEL_I;
      st_nxt.chan  = CHAN_SEL_I;
    end
    // One-hot channel connect, opened during pump and hold
    st_nxt.connect = '0;
    if (sif.buf_on || sif.direct_on) begin
      st_nxt.connect[st_r.chan] = 1'b1;
    end
    st_nxt.pump   = sif.pump_on;
    st_nxt.bufs   = sif.buf_on;
    st_nxt.direct = sif.direct_on;
    st_nxt.hold   = sif.hold_on;
    st_nxt.busy   = sif.busy | st_r.start;
    // Store the result at the end of the conversion
    if (sif.done) begin
      st_nxt.ram_wr   = 1'b1;
      st_nxt.ram_addr = res_addr;
      st_nxt.ram_data = {6'h00, RESULT_DATA_I};
    end
  end

  // State register; list pointers clear at reset
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      st_r          <= '0;
      st_r.base_ptr <= `ALASP_PTR_RST;
      st_r.l1_off   <= `ALASP_OFF_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign REG_RDATA_O     = st_r.rdata;
  assign CHAN_CONNECT_O  = st_r.connect;
  assign PUMP_O          = st_r.pump;
  assign BUF_SAMPLE_O    = st_r.bufs;
  assign DIRECT_SAMPLE_O = st_r.direct;
  assign HOLD_O          = st_r.hold;
  assign BUSY_O          = st_r.busy;
  assign RAM_WR_O        = st_r.ram_wr;
  assign RAM_ADDR_O      = st_r.ram_addr;
  assign RAM_WDATA_O     = st_r.ram_data;

endmodule : alasp_top

// file: src/alasp_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ALASP_MAP_SVH
`define ALASP_MAP_SVH

// ****************************************************************
// Register offsets (byte addresses on the plain port)
// ****************************************************************
`define ALASP_OFF_RBP_HIGH   8'h21
`define ALASP_OFF_RBP_MID    8'h22
`define ALASP_OFF_RBP_LOW    8'h23
`define ALASP_OFF_L0_OFFSET  8'h24
`define ALASP_OFF_L1_OFFSET  8'h25
`define ALASP_OFF_CONTROL    8'h26
`define ALASP_OFF_STATUS     8'h27

// ****************************************************************
// Field positions and widths
// ****************************************************************
`define ALASP_PTR_W          18
`define ALASP_ADDR_W         20
`define ALASP_OFF_W          7
`define ALASP_IDX_W          6
`define ALASP_SMP_W          5
`define ALASP_CHAN_W         4
`define ALASP_CTL_EN_BIT     0
`define ALASP_CTL_SACC_BIT   1
`define ALASP_CTL_LSEL_BIT   2

// ****************************************************************
// Reset values
// ****************************************************************
`define ALASP_PTR_RST        18'h00000
`define ALASP_OFF_RST        7'h00
`define ALASP_LIST0_OFFSET   7'h00

// ****************************************************************
// Timing counts in converter clock cycles
// ****************************************************************
`define ALASP_PUMP_CYC       5'h02
`define ALASP_BUF_CYC        5'h02
`define ALASP_SMP_BASE       5'h04
`define ALASP_SMP_MAX_CODE   5'h14
`define ALASP_CONV_CYC       5'h0A

`endif

// file: src/alasp_pkg.sv
// Types shared by the list address and sample phase block
package alasp_pkg;

  // Sequencer phases
  typedef enum logic [2:0] {
    ALASP_IDLE   = 3'b000,
    ALASP_PUMP   = 3'b001,
    ALASP_BUFFER = 3'b010,
    ALASP_DIRECT = 3'b011,
    ALASP_HOLD   = 3'b100
  } alasp_phase_type;

endpackage : alasp_pkg

// file: src/alasp_seq_if.sv
// Interface carrying sequencer control between top and sequencer
`timescale 1ns/1ps
`include "alasp_map.svh"

interface alasp_seq_if;
  logic                        start;
  logic [`ALASP_SMP_W-1:0]     smp_sel;
  logic                        busy;
  logic                        done;
  logic                        pump_on;
  logic                        buf_on;
  logic                        direct_on;
  logic                        hold_on;

  modport top (
    output start,
    output smp_sel,
    input  busy,
    input  done,
    input  pump_on,
    input  buf_on,
    input  direct_on,
    input  hold_on
  );

  modport seq (
    input  start,
    input  smp_sel,
    output busy,
    output done,
    output pump_on,
    output buf_on,
    output direct_on,
    output hold_on
  );
endinterface : alasp_seq_if

// file: src/alasp_seq.sv
// Sample phase sequencer: pump, buffered, direct and hold phases
`timescale 1ns/1ps
`include "alasp_map.svh"

module alasp_seq (
  // Clock and reset
  input  wire logic   clk_i,
  input  wire logic   reset_i,
  // Converter clock enable
  input  wire logic   cc_en_i,
  // Control towards top
  alasp_seq_if.seq    sif
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    alasp_pkg::alasp_phase_type phase;
    logic [4:0]                 cnt;
    logic [4:0]                 smp_len;
    logic                       done;
    logic                       pend;
  } alasp_seq_state_type;

  alasp_seq_state_type st_r;
  alasp_seq_state_type st_nxt;

  // Phase sequencing; counts advance only on converter clock enables
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    case (st_r.phase)
      alasp_pkg::ALASP_IDLE: begin
        // Start waits for a converter clock edge, else the pump is short
        if (sif.start || st_r.pend) begin
          if (cc_en_i) begin
            st_nxt.phase = alasp_pkg::ALASP_PUMP;
            st_nxt.cnt   = 5'h00;
            st_nxt.pend  = 1'b0;
          end else begin
            st_nxt.pend = 1'b1;
          end
          // Reserved codes clamp to the longest time
          st_nxt.smp_len = (sif.smp_sel > `ALASP_SMP_MAX_CODE) ?
                           `ALASP_SMP_MAX_CODE + `ALASP_SMP_BASE :
                           sif.smp_sel + `ALASP_SMP_BASE;
        end
      end
      alasp_pkg::ALASP_PUMP: begin
        if (cc_en_i) begin
          if (st_r.cnt == `ALASP_PUMP_CYC - 5'h01) begin
            st_nxt.phase = alasp_pkg::ALASP_BUFFER;
            st_nxt.cnt   = 5'h00;
          end else begin
            st_nxt.cnt = st_r.cnt + 5'h01;
          end
        end
      end
      alasp_pkg::ALASP_BUFFER: begin
        if (cc_en_i) begin
          st_nxt.cnt = st_r.cnt + 5'h01;
          if (st_r.cnt == `ALASP_BUF_CYC - 5'h01) begin
            st_nxt.phase = alasp_pkg::ALASP_DIRECT;
          end
        end
      end
      alasp_pkg::ALASP_DIRECT: begin
        if (cc_en_i) begin
          if (st_r.cnt == st_r.smp_len - 5'h01) begin
            st_nxt.phase = alasp_pkg::ALASP_HOLD;
            st_nxt.cnt   = 5'h00;
          end else begin
            st_nxt.cnt = st_r.cnt + 5'h01;
          end
        end
      end
      alasp_pkg::ALASP_HOLD: begin
        if (cc_en_i) begin
          if (st_r.cnt == `ALASP_CONV_CYC - 5'h01) begin
            st_nxt.phase = alasp_pkg::ALASP_IDLE;
            st_nxt.cnt   = 5'h00;
            st_nxt.done  = 1'b1;
          end else begin
            st_nxt.cnt = st_r.cnt + 5'h01;
          end
        end
      end
      default: begin
        st_nxt.phase = alasp_pkg::ALASP_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_r <= '{alasp_pkg::ALASP_IDLE, 5'h00, 5'h00, 1'b0, 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Phase decodes towards top
  assign sif.busy      = (st_r.phase != alasp_pkg::ALASP_IDLE) | st_r.pend;
  assign sif.done      = st_r.done;
  assign sif.pump_on   = (st_r.phase == alasp_pkg::ALASP_PUMP);
  assign sif.buf_on    = (st_r.phase == alasp_pkg::ALASP_BUFFER);
  assign sif.direct_on = (st_r.phase == alasp_pkg::ALASP_DIRECT);
  assign sif.hold_on   = (st_r.phase == alasp_pkg::ALASP_HOLD);

endmodule : alasp_seq

// file: verif/alasp_ram_model.sv
// System RAM model that records each result store
`timescale 1ns/1ps
`include "alasp_map.svh"

module alasp_ram_model (
  // Clock
  input  wire logic                     clk_i,
  // Store port from the converter
  input  wire logic                     wr_i,
  input  wire logic [`ALASP_ADDR_W-1:0] addr_i,
  input  wire logic [15:0]              data_i,
  // Observed traffic
  output logic      [`ALASP_ADDR_W-1:0] last_addr_o,
  output logic      [15:0]              last_data_o,
  output logic      [7:0]               n_wr_o
);
  // RAM never stalls, so one pulse is one stored result
  initial n_wr_o = 8'h00;
  always @(posedge clk_i) begin
    if (wr_i) begin
      last_addr_o <= addr_i;
      last_data_o <= data_i;
      n_wr_o      <= n_wr_o + 8'h01;
    end
  end
endmodule : alasp_ram_model

// file: verif/alasp_top_asserts.sv
// Concurrent checks on the ports of the list address and sample block
`timescale 1ns/1ps
`include "alasp_map.svh"

module alasp_top_asserts (
  // Clock and reset
  input  wire logic                          SYS_CLK_I,
  input  wire logic                          RESET_I,
  // Register read side
  input  wire logic [7:0]                    REG_ADDR_I,
  input  wire logic                          REG_RD_I,
  input  wire logic [7:0]                    REG_RDATA_O,
  // Switch controls and store
  input  wire logic [(1<<`ALASP_CHAN_W)-1:0] CHAN_CONNECT_O,
  input  wire logic                          PUMP_O,
  input  wire logic                          BUF_SAMPLE_O,
  input  wire logic                          DIRECT_SAMPLE_O,
  input  wire logic                          HOLD_O,
  input  wire logic                          RAM_WR_O,
  input  wire logic [`ALASP_ADDR_W-1:0]      RAM_ADDR_O
);
  // ************************************************************
  // Phase and register checks
  // ************************************************************
  logic [7:0] hold_cnt_r;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  // Counter instead of a long repetition keeps the tools fast
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I || !HOLD_O) hold_cnt_r <= 8'h00;
    else hold_cnt_r <= hold_cnt_r + 8'h01;
  end
  a_pump_len: assert property ($rose(PUMP_O) |-> PUMP_O[*4] ##1 !PUMP_O)
    else $error("pump phase length wrong");
  a_pump_first: assert property ($rose(BUF_SAMPLE_O) |-> $past(PUMP_O))
    else $error("sampling began without pump");
  a_buf_then_direct: assert property ($rose(BUF_SAMPLE_O) |->
    BUF_SAMPLE_O[*4] ##1 (DIRECT_SAMPLE_O && !BUF_SAMPLE_O))
    else $error("buffered phase length wrong");
  a_hold_after: assert property ($rose(HOLD_O) |-> $past(DIRECT_SAMPLE_O))
    else $error("hold not after direct phase");
  a_hold_open: assert property (HOLD_O |-> CHAN_CONNECT_O == '0)
    else $error("input connected during hold");
  a_hold_len: assert property ($fell(HOLD_O) |-> hold_cnt_r == 8'h14)
    else $error("hold length wrong");
  a_one_chan: assert property ((BUF_SAMPLE_O || DIRECT_SAMPLE_O) |->
    $onehot(CHAN_CONNECT_O))
    else $error("not one channel connected");
  a_phase_excl: assert property ($onehot0({PUMP_O, BUF_SAMPLE_O,
    DIRECT_SAMPLE_O, HOLD_O}))
    else $error("two phases at once");
  a_off0_zero: assert property (REG_RD_I && REG_ADDR_I == 8'h24 |=>
    REG_RDATA_O == 8'h00)
    else $error("list zero offset not zero");
  a_even_store: assert property (RAM_WR_O |-> !RAM_ADDR_O[0] ##1 !RAM_WR_O)
    else $error("store odd or too long");
  c_pump: cover property ($rose(PUMP_O));
  c_store: cover property (RAM_WR_O);
  c_off0_read: cover property (REG_RD_I && REG_ADDR_I == 8'h24);
endmodule : alasp_top_asserts

bind alasp_top alasp_top_asserts u_chk (.SYS_CLK_I(SYS_CLK_I),
  .RESET_I(RESET_I), .REG_ADDR_I(REG_ADDR_I), .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O), .CHAN_CONNECT_O(CHAN_CONNECT_O),
  .PUMP_O(PUMP_O), .BUF_SAMPLE_O(BUF_SAMPLE_O),
  .DIRECT_SAMPLE_O(DIRECT_SAMPLE_O), .HOLD_O(HOLD_O),
  .RAM_WR_O(RAM_WR_O), .RAM_ADDR_O(RAM_ADDR_O));

// file: verif/alasp_top_test.sv
// Self-checking bench for the list address and sample phase block
`timescale 1ns/1ps
`include "alasp_map.svh"

module alasp_top_test;
  // ************************************************************
  // Signals, design and RAM model
  // ************************************************************
  logic        clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
  logic        start = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
  logic [4:0]  sample_time_select = 5'h00;
  logic [3:0]  chan = 4'h0;
  logic [5:0]  idx = 6'h00;
  logic [9:0]  res = 10'h000;
  logic [15:0] chan_on, ram_wdata, last_data;
  logic        pump, bufs, dirs, hold, busy, ram_wr;
  logic [19:0] ram_addr, last_addr;
  logic [7:0]  n_wr;
  int          n_errors = 0, tests_run = 0, cyc = 0;
  logic [7:0]  regs [6] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h30};
  logic [7:0]  mask [6] = '{8'h0F, 8'hFF, 8'hFC, 8'h00, 8'h7F, 8'h00};
  logic [4:0]  codes [4] = '{5'h00, 5'h14, 5'h15, 5'h1F};

  alasp_top dut (.SYS_CLK_I(clk), .RESET_I(rst), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr_s), .REG_RD_I(rd_s),
    .REG_RDATA_O(rdata), .CONV_START_I(start), .SMP_SEL_I(sample_time_select),
    .CHAN_SEL_I(chan), .RESULT_INDEX_I(idx), .RESULT_DATA_I(res),
    .CHAN_CONNECT_O(chan_on), .PUMP_O(pump), .BUF_SAMPLE_O(bufs),
    .DIRECT_SAMPLE_O(dirs), .HOLD_O(hold), .BUSY_O(busy),
    .RAM_WR_O(ram_wr), .RAM_ADDR_O(ram_addr), .RAM_WDATA_O(ram_wdata));
  alasp_ram_model ram (.clk_i(clk), .wr_i(ram_wr), .addr_i(ram_addr),
    .data_i(ram_wdata), .last_addr_o(last_addr),
    .last_data_o(last_data), .n_wr_o(n_wr));

  always #50 clk = ~clk;

  // Hang guard: a full run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [19:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk($sformatf("reg %h", a), {12'h000, rdata}, {12'h000, e});
  endtask : rd

  // Runs one conversion, timing each phase and the stored result
  task automatic conv(input logic [4:0] code, input logic lsel);
    int n_p, n_b, n_d, n_h, bad, nb, lim, n;
    logic [7:0]  cnt0;
    logic [19:0] exp;
    n_p = 0; n_b = 0; n_d = 0; n_h = 0; bad = 0; nb = 0;
    cnt0 = n_wr;
    n = (code > 5'h14) ? 24 : int'(code) + 4;
    exp = 20'hFFF00 + 20'(2 * ((lsel ? 5 : 0) + 32 + int'(code)));
    wr(8'h26, {5'h00, lsel, 2'b01});
    @(posedge clk);
    sample_time_select <= code;
    chan <= code[3:0];
    idx <= {1'b1, code};
    res <= {code, 5'h15};
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (lim = 0; lim < 300 && ram_wr !== 1'b1; lim++) begin
      @(posedge clk);
      #1;
      n_p += pump; n_b += bufs; n_d += dirs; n_h += hold;
      if ((bufs || dirs) && chan_on !== (16'h0001 << code[3:0])) bad++;
      if (hold && chan_on !== 16'h0000) bad++;
      if ((pump || bufs || dirs || hold) && busy !== 1'b1) nb++;
    end
    @(posedge clk);
    #1;
    chk("pump cycles", n_p, 4);
    chk("buffer cycles", n_b, 4);
    chk("direct cycles", n_d, 2 * (n - 2));
    chk("hold cycles", n_h, 20);
    chk("channel", bad, 0);
    chk("busy in phases", nb, 0);
    chk("store addr", last_addr, exp);
    chk("store data", last_data, {10'h000, code, 5'h15});
    chk("store count", n_wr, cnt0 + 8'h01);
  endtask : conv

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (regs[i]) rd(regs[i], 8'h00);
    $display("test reset values done");
    foreach (regs[i]) wr(regs[i], 8'hFF);
    foreach (regs[i]) rd(regs[i], mask[i]);
    $display("test field masks done");
    wr(8'h26, 8'h01);
    wr(8'h22, 8'h00);
    wr(8'h25, 8'h00);
    rd(8'h22, 8'hFF);
    rd(8'h25, 8'h7F);
    wr(8'h26, 8'h03);
    rd(8'h26, 8'h03);
    wr(8'h23, 8'h00);
    wr(8'h25, 8'h05);
    rd(8'h23, 8'h00);
    rd(8'h25, 8'h05);
    $display("test write lock done");
    foreach (codes[i]) conv(codes[i], i[0]);
    $display("test conversions done");
    wr(8'h26, 8'h00);
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (30) @(posedge clk);
    #1 chk("disabled start", {11'h000, busy, n_wr}, {12'h000, 8'h04});
    $display("test disabled start done");
    end_sim();
  end
endmodule : alasp_top_test
